// *** inc/qbri_regs.svh ***
// Register indices, field positions, reset values and constants of the burst read query block.
`ifndef QBRI_REGS_SVH
`define QBRI_REGS_SVH

// Query table indices; the byte address on the bus is four times the index.
`define QBRI_IDX_BASE       10'h10A
`define QBRI_IDX_PAGE       10'h127
`define QBRI_IDX_COUNT      10'h128
`define QBRI_IDX_OPT1       10'h129
`define QBRI_IDX_OPT2       10'h12A
`define QBRI_IDX_OPT3       10'h12B
`define QBRI_IDX_OPT4       10'h12C
`define QBRI_IDX_PART       10'h12D

// Read configuration and burst status words, placed after the query table.
`define QBRI_IDX_CTRL       10'h140
`define QBRI_IDX_STAT       10'h141

// Constant query contents.
`define QBRI_VAL_PAGE       8'h03
`define QBRI_VAL_COUNT      8'h04
`define QBRI_VAL_OPT1       8'h01
`define QBRI_VAL_OPT2       8'h02
`define QBRI_VAL_OPT3       8'h03
`define QBRI_VAL_OPT4       8'h07
`define QBRI_VAL_PART       8'h00

// Field positions and widths.
`define QBRI_CODE_W         3
`define QBRI_STAT_CONT_BIT  3
`define QBRI_STAT_OK_BIT    4
`define QBRI_STAT_LEN_LSB   8

// Reset value of the burst length code and the code for unbounded linear bursts.
`define QBRI_CTRL_RST       3'h7
`define QBRI_CODE_CONT      3'h7

`endif

// *** inc/qbri_pkg.sv ***
// Types shared by the burst read query block.
package qbri_pkg;
  typedef logic [11:0] qbri_addr_t;
  typedef logic [31:0] qbri_data_t;
  typedef logic [9:0]  qbri_idx_t;
  typedef logic [7:0]  qbri_byte_t;
  typedef logic [2:0]  qbri_code_t;
endpackage

// *** logic/qbri_query_rom.sv ***
// Constant byte-wide query table entries for the burst read section.
`timescale 1ns/1ps
`include "qbri_regs.svh"

module qbri_query_rom (
  input  wire qbri_pkg::qbri_idx_t  idx,
  input  wire qbri_pkg::qbri_byte_t part_regions,
  output logic                      hit,
  output qbri_pkg::qbri_byte_t      entry
);
  import qbri_pkg::*;

  // Hit flag in bit 8, entry byte below; unlisted indices miss and read zero.
  function automatic logic [8:0] qbri_lookup(input qbri_idx_t i, input qbri_byte_t part);
    case (i)
      `QBRI_IDX_PAGE:  qbri_lookup = {1'b1, `QBRI_VAL_PAGE};
      `QBRI_IDX_COUNT: qbri_lookup = {1'b1, `QBRI_VAL_COUNT};
      `QBRI_IDX_OPT1:  qbri_lookup = {1'b1, `QBRI_VAL_OPT1};
      `QBRI_IDX_OPT2:  qbri_lookup = {1'b1, `QBRI_VAL_OPT2};
      `QBRI_IDX_OPT3:  qbri_lookup = {1'b1, `QBRI_VAL_OPT3};
      `QBRI_IDX_OPT4:  qbri_lookup = {1'b1, `QBRI_VAL_OPT4};
      `QBRI_IDX_PART:  qbri_lookup = {1'b1, part};
      default:         qbri_lookup = 9'h000;
    endcase
  endfunction

  // Split the lookup into the hit flag and the entry byte.
  wire [8:0] look = qbri_lookup(idx, part_regions);
  assign hit   = look[8];
  assign entry = look[7:0];
endmodule

// *** logic/qbri_burst_decode.sv ***
// Decoder from a three-bit burst code to its length in words and its support status.
`timescale 1ns/1ps
`include "qbri_regs.svh"

module qbri_burst_decode (
  input  wire qbri_pkg::qbri_code_t code,
  output qbri_pkg::qbri_byte_t      len_words,
  output logic                      continuous,
  output logic                      supported
);
  import qbri_pkg::*;

  localparam qbri_byte_t OPTS [4] = '{`QBRI_VAL_OPT1, `QBRI_VAL_OPT2, `QBRI_VAL_OPT3, `QBRI_VAL_OPT4};

  // One comparator per advertised option; a code is supported when any matches.
  wire [3:0] match;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_opt
      assign match[g] = (code == OPTS[g][2:0]);
    end
  endgenerate

  // Code n gives 2^(n+1) words; the unbounded code reports zero length instead.
  assign continuous = (code == `QBRI_CODE_CONT);
  assign len_words  = continuous ? 8'h00 : 8'(8'h02 << code);
  assign supported  = |match;
endmodule

// *** logic/qbri_query_top.sv ***
// APB slave that serves the burst read query table and a burst length configuration word.
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`include "qbri_regs.svh"

module qbri_query_top #(
  parameter logic [7:0] PART_REGIONS = `QBRI_VAL_PART
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire qbri_pkg::qbri_addr_t paddr,
  input  wire qbri_pkg::qbri_data_t pwdata,
  input  wire logic [3:0]       pstrb,
  output qbri_pkg::qbri_data_t  prdata,
  output logic                  pready,
  output logic                  pslverr,
  output qbri_pkg::qbri_code_t  burst_code,
  output qbri_pkg::qbri_byte_t  burst_len_words,
  output logic                  burst_continuous,
  output logic                  burst_code_ok
);
  import qbri_pkg::*;

  // Phase decode of the APB transfer.
  wire       setup  = psel & ~penable;
  wire       access = psel & penable;
  wire       rd_acc = access & ~pwrite;

  // Address decode; only word-aligned addresses hit anything.
  qbri_idx_t idx;
  wire       aligned;
  assign idx     = paddr[11:2];
  assign aligned = (paddr[1:0] == 2'h0);

  // Constant query table lookup.
  logic       rom_hit;
  qbri_byte_t rom_byte;
  qbri_query_rom u_rom (
    .idx          (idx),
    .part_regions (PART_REGIONS),
    .hit          (rom_hit),
    .entry        (rom_byte)
  );

  // Slot selects for the table and the two own words.
  wire q_sel    = aligned & rom_hit;
  wire ctrl_sel = aligned & (idx == `QBRI_IDX_CTRL);
  wire stat_sel = aligned & (idx == `QBRI_IDX_STAT);
  wire map_hit  = q_sel | ctrl_sel | stat_sel;

  // Writes into read-only slots are refused with an error and store nothing.
  wire ro_write = pwrite & (q_sel | stat_sel);
  wire err_next = ~map_hit | ro_write;

  // Burst length configuration, written by software and steering the decoder.
  qbri_code_t ctrl_reg;
  qbri_code_t ctrl_next;
  wire        ctrl_wr = access & pwrite & ctrl_sel & pstrb[0];
  assign ctrl_next = ctrl_wr ? pwdata[2:0] : ctrl_reg;

  // Decoder of the configured code.
  qbri_byte_t dec_len;
  logic       dec_cont;
  logic       dec_ok;
  qbri_burst_decode u_dec (
    .code       (ctrl_reg),
    .len_words  (dec_len),
    .continuous (dec_cont),
    .supported  (dec_ok)
  );

  // Registered burst state shown on the outputs and in the status word.
  qbri_code_t code_reg;
  qbri_byte_t len_reg;
  logic       cont_reg;
  logic       ok_reg;

  // Status word: code, continuous flag, supported flag and length in words.
  qbri_data_t stat_word;
  assign stat_word = {16'h0000, len_reg, 3'h0, ok_reg, cont_reg, code_reg};

  // Read data selection; the table byte sits in the low lane with zeros above.
  qbri_data_t rdata_sel;
  qbri_data_t rdata_next;
  assign rdata_sel  = q_sel    ? {24'h000000, rom_byte} :
                      ctrl_sel ? {29'h00000000, ctrl_reg} :
                      stat_sel ? stat_word : 32'h00000000;
  assign rdata_next = (~pwrite & map_hit) ? rdata_sel : 32'h00000000;

  // Answer registers, loaded in the setup phase so data comes from flip-flops.
  qbri_data_t prdata_reg;
  logic       slverr_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
      slverr_reg <= 1'b0;
    end else if (setup) begin
      prdata_reg <= rdata_next;
      slverr_reg <= err_next;
    end
  end

  // Configuration register; only a write to its own word can change it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `QBRI_CTRL_RST;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Decoded burst state, one cycle behind the configuration to keep outputs clean.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_reg <= `QBRI_CTRL_RST;
      len_reg  <= 8'h00;
      cont_reg <= 1'b1;
      ok_reg   <= 1'b1;
    end else begin
      code_reg <= ctrl_reg;
      len_reg  <= dec_len;
      cont_reg <= dec_cont;
      ok_reg   <= dec_ok;
    end
  end

  // The slave never waits: every access phase completes at its first edge.
  // This costs nothing because all answers are prepared during setup.
  assign pready           = 1'b1;
  assign prdata           = prdata_reg;
  assign pslverr          = slverr_reg & access;
  assign burst_code       = code_reg;
  assign burst_len_words  = len_reg;
  assign burst_continuous = cont_reg;
  assign burst_code_ok    = ok_reg;

  // Checks on the answers and the burst state.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_page_size;
    (rd_acc && aligned && idx == `QBRI_IDX_PAGE) |-> (prdata == {24'h000000, `QBRI_VAL_PAGE}) && !pslverr;
  endproperty
  a_page_size: assert property (p_page_size) else $error("page size entry wrong");

  property p_opt_count;
    (rd_acc && aligned && idx == `QBRI_IDX_COUNT) |-> prdata[7:0] == `QBRI_VAL_COUNT;
  endproperty
  a_opt_count: assert property (p_opt_count) else $error("option count entry wrong");

  property p_opt_reserved;
    (rd_acc && aligned && idx >= `QBRI_IDX_OPT1 && idx <= `QBRI_IDX_OPT4) |-> prdata[7:3] == 5'h00;
  endproperty
  a_opt_reserved: assert property (p_opt_reserved) else $error("option reserved bits set");

  property p_cont_mode;
    (ctrl_reg == `QBRI_CODE_CONT) |=> burst_continuous && burst_len_words == 8'h00;
  endproperty
  a_cont_mode: assert property (p_cont_mode) else $error("continuous code not reported");

  property p_opt_values;
    rd_acc && aligned |->
      (idx != `QBRI_IDX_OPT1 || prdata[7:0] == 8'h01) && (idx != `QBRI_IDX_OPT2 || prdata[7:0] == 8'h02) &&
      (idx != `QBRI_IDX_OPT3 || prdata[7:0] == 8'h03) && (idx != `QBRI_IDX_OPT4 || prdata[7:0] == 8'h07);
  endproperty
  a_opt_values: assert property (p_opt_values) else $error("burst option entry wrong");

  property p_copy_len;
    (ctrl_wr && pwdata[2:0] == 3'h3) |=> ##1 burst_len_words == 8'h10 && burst_code_ok && !burst_continuous;
  endproperty
  a_copy_len: assert property (p_copy_len) else $error("copied code gives wrong length");

  property p_part_count;
    (rd_acc && aligned && idx == `QBRI_IDX_PART) |-> prdata == {24'h000000, PART_REGIONS};
  endproperty
  a_part_count: assert property (p_part_count) else $error("partition count entry wrong");

  property p_low_lane;
    (rd_acc && q_sel) |-> prdata[31:8] == 24'h000000 && !pslverr;
  endproperty
  a_low_lane: assert property (p_low_lane) else $error("query upper lanes not zero");

  property p_no_side_effect;
    (access && !ctrl_sel) |=> $stable(ctrl_reg) ##1 $stable(burst_code);
  endproperty
  a_no_side_effect: assert property (p_no_side_effect) else $error("access altered configuration");

  // Helper for the configuration load check, so that the sampled-value
  // function only ever looks at a plain signal and never at a part-select.
  qbri_code_t wr_code;
  assign wr_code = pwdata[2:0];

  // Bus answers: refused transfers must say so, and accepted ones must not.
  // The error flag is captured at setup, so a master that moves the address
  // between the two phases would be answered for the old address.
  property p_unmapped_err;
    (access && !map_hit) |-> pslverr;
  endproperty
  a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped access not refused");

  property p_unmapped_zero;
    (rd_acc && !map_hit) |-> prdata == 32'h00000000;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read returned data");

  property p_unaligned_err;
    (access && paddr[1:0] != 2'h0) |-> pslverr;
  endproperty
  a_unaligned_err: assert property (p_unaligned_err) else $error("unaligned access not refused");

  property p_ro_refused;
    (access && pwrite && (q_sel || stat_sel)) |-> pslverr;
  endproperty
  a_ro_refused: assert property (p_ro_refused) else $error("read-only write not refused");

  property p_good_write;
    (access && pwrite && ctrl_sel) |-> !pslverr;
  endproperty
  a_good_write: assert property (p_good_write) else $error("configuration write refused");

  // Read data only moves at a setup edge, so it stands through the access phase.
  property p_prdata_hold;
    !setup |=> $stable(prdata);
  endproperty
  a_prdata_hold: assert property (p_prdata_hold) else $error("read data moved outside setup");

  // Configuration register: loaded from the low bits, untouched without the strobe.
  property p_ctrl_load;
    ctrl_wr |=> ctrl_reg == $past(wr_code);
  endproperty
  a_ctrl_load: assert property (p_ctrl_load) else $error("configuration not loaded");

  property p_strobe_keep;
    (access && pwrite && ctrl_sel && !pstrb[0]) |=> $stable(ctrl_reg);
  endproperty
  a_strobe_keep: assert property (p_strobe_keep) else $error("unstrobed write changed configuration");

  // The answer was captured one edge before the access edge, hence the past value.
  property p_ctrl_read;
    (rd_acc && ctrl_sel) |-> prdata == {29'h00000000, $past(ctrl_reg)};
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("configuration read back wrong");

  // Decoded state follows the configuration by exactly one edge.
  // A host that polls the status right after a write may see the old code once.
  property p_code_follow;
    1'b1 |=> burst_code == $past(ctrl_reg);
  endproperty
  a_code_follow: assert property (p_code_follow) else $error("burst code does not follow configuration");

  property p_len_four;
    (burst_code == 3'h1) |-> burst_len_words == 8'h04 && burst_code_ok && !burst_continuous;
  endproperty
  a_len_four: assert property (p_len_four) else $error("code one is not four words");

  property p_len_eight;
    (burst_code == 3'h2) |-> burst_len_words == 8'h08 && burst_code_ok && !burst_continuous;
  endproperty
  a_len_eight: assert property (p_len_eight) else $error("code two is not eight words");

  property p_len_sixteen;
    (burst_code == 3'h3) |-> burst_len_words == 8'h10 && burst_code_ok && !burst_continuous;
  endproperty
  a_len_sixteen: assert property (p_len_sixteen) else $error("code three is not sixteen words");

  // Only the four advertised codes count as supported.
  property p_ok_set;
    burst_code_ok == (burst_code == 3'h1 || burst_code == 3'h2 || burst_code == 3'h3 || burst_code == 3'h7);
  endproperty
  a_ok_set: assert property (p_ok_set) else $error("supported flag disagrees with options");

  property p_cont_only;
    burst_continuous |-> burst_code == `QBRI_CODE_CONT;
  endproperty
  a_cont_only: assert property (p_cont_only) else $error("continuous flag on a bounded code");

  // Status fields were captured at setup, one edge before the access edge.
  property p_stat_read;
    (rd_acc && stat_sel) |->
      prdata[2:0] == $past(burst_code) && prdata[15:8] == $past(burst_len_words) &&
      prdata[4:3] == {$past(burst_code_ok), $past(burst_continuous)} && prdata[31:16] == 16'h0000;
  endproperty
  a_stat_read: assert property (p_stat_read) else $error("status word wrong");

  // Main scenarios.
  c_page_read: cover property (rd_acc && aligned && idx == `QBRI_IDX_PAGE);
  c_cont_set:  cover property (ctrl_wr && pwdata[2:0] == `QBRI_CODE_CONT);
  c_ro_error:  cover property (access && pwrite && q_sel && pslverr);
  c_bad_code:  cover property (!burst_code_ok);
  c_stat_read: cover property (rd_acc && stat_sel);
endmodule

// *** tb/qbri_host_model.sv ***
// Host controller model that reads and writes the query block over APB.
`timescale 1ns/1ps

module qbri_host_model (
  input  wire logic                 pclk,
  input  wire logic                 pready,
  input  wire qbri_pkg::qbri_data_t prdata,
  input  wire logic                 pslverr,
  output logic                      psel,
  output logic                      penable,
  output logic                      pwrite,
  output qbri_pkg::qbri_addr_t      paddr,
  output qbri_pkg::qbri_data_t      pwdata,
  output logic [3:0]                pstrb
);
  import qbri_pkg::*;

  // The bus is quiet from time zero so nothing is selected during reset.
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'h0;
  end

  // One transfer; the whole word is taken, as the width is not assumed to be a byte.
  task automatic xfer(input logic w, input qbri_addr_t a, input qbri_data_t d, input logic [3:0] s,
                      output qbri_data_t rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // The request stands until pready is seen; only the bench timeout ends a hang.
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// *** tb/query_burst_read_info_test.sv ***
// Self-checking bench for the burst read query block.
`timescale 1ns/1ps
`include "qbri_regs.svh"

module query_burst_read_info_test;
  import qbri_pkg::*;
  logic       pclk, presetn, psel, penable, pwrite, pready, pslverr, err, cont, ok;
  qbri_addr_t paddr;
  qbri_data_t pwdata, prdata, rd;
  logic [3:0] pstrb;
  qbri_code_t code;
  qbri_byte_t len;
  int         failures, n_tests, cycles;
  qbri_addr_t qa [7];
  qbri_byte_t qv [7];
  qbri_byte_t el;

  qbri_query_top #(.PART_REGIONS(8'h00)) u_qbri_query_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .burst_code(code), .burst_len_words(len),
    .burst_continuous(cont), .burst_code_ok(ok));

  qbri_host_model u_qbri_host_model (
    .pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));

  // Compare one value and count it.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Report the counts and end the run.
  task close_out;
    $display("failures=%0d n_tests=%0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Clock at 8 ns.
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // A hang is cut short well beyond the some 140 cycles the run needs.
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      close_out();
    end
  end

  // Main sequence: table reads, every burst code, refused and ignored accesses.
  initial begin
    presetn = 1'b0;
    failures = 0;
    n_tests = 0;
    cycles = 0;
    qa = '{{`QBRI_IDX_PAGE, 2'b00}, {`QBRI_IDX_COUNT, 2'b00}, {`QBRI_IDX_OPT1, 2'b00},
           {`QBRI_IDX_OPT2, 2'b00}, {`QBRI_IDX_OPT3, 2'b00}, {`QBRI_IDX_OPT4, 2'b00},
           {`QBRI_IDX_PART, 2'b00}};
    qv = '{8'h03, 8'h04, 8'h01, 8'h02, 8'h03, 8'h07, 8'h00};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check({cont, ok, code, len}, {1'b1, 1'b1, 3'h7, 8'h00});
    // Every query entry, upper lines zero, twice so a read cannot disturb it.
    for (int k = 0; k < 14; k++) begin
      u_qbri_host_model.xfer(1'b0, qa[k % 7], 32'h0, 4'hF, rd, err);
      check(rd, {24'h0, qv[k % 7]});
      check(err, 1'b0);
    end
    // Each three-bit option code copied straight into the burst length bits.
    for (int c = 0; c < 8; c++) begin
      u_qbri_host_model.xfer(1'b1, {`QBRI_IDX_CTRL, 2'b00}, 32'(c), 4'hF, rd, err);
      repeat (3) @(posedge pclk);
      el = (c == 7) ? 8'h00 : 8'(1 << (c + 1));
      check({cont, ok, code, len}, {c == 7, c inside {1, 2, 3, 7}, 3'(c), el});
      u_qbri_host_model.xfer(1'b0, {`QBRI_IDX_STAT, 2'b00}, 32'h0, 4'hF, rd, err);
      check(rd, {16'h0, el, 3'h0, c inside {1, 2, 3, 7}, c == 7, 3'(c)});
    end
    // A write to a query entry is refused and stores nothing.
    u_qbri_host_model.xfer(1'b1, qa[2], 32'h0000_00FF, 4'hF, rd, err);
    check(err, 1'b1);
    u_qbri_host_model.xfer(1'b0, qa[2], 32'h0, 4'hF, rd, err);
    check(rd, 32'h0000_0001);
    // Unmapped read answers an error with zero data.
    u_qbri_host_model.xfer(1'b0, 12'h600, 32'h0, 4'hF, rd, err);
    check(err, 1'b1);
    check(rd, 32'h0);
    // Unaligned read of a table entry is refused with zero data.
    u_qbri_host_model.xfer(1'b0, {`QBRI_IDX_PAGE, 2'b01}, 32'h0, 4'hF, rd, err);
    check(err, 1'b1);
    check(rd, 32'h0);
    // A write to the status word is refused.
    u_qbri_host_model.xfer(1'b1, {`QBRI_IDX_STAT, 2'b00}, 32'h0, 4'hF, rd, err);
    check(err, 1'b1);
    // Without the low byte strobe the configuration keeps its code.
    u_qbri_host_model.xfer(1'b1, {`QBRI_IDX_CTRL, 2'b00}, 32'h2, 4'hE, rd, err);
    repeat (3) @(posedge pclk);
    check({err, code}, {1'b0, 3'h7});
    // The configuration word reads back the code that was last stored.
    u_qbri_host_model.xfer(1'b0, {`QBRI_IDX_CTRL, 2'b00}, 32'h0, 4'hF, rd, err);
    check(err, 1'b0);
    check(rd, 32'h7);
    close_out();
  end
endmodule
